// File: testbench.sv
/*
  self-checking bench for the voltage-code step controller.
  assumes the package constants and a 40 MHz mclk.
*/
`timescale 1ns/1ps
module testbench;
  logic                        mclk;
  logic                        nrst;
  logic                        ce;
  logic [5:0]                  req;
  logic                        b5, b4, b3, b2, b1, b0;
  logic [vdsc_pkg::REF_W-1:0]  ref_v;
  logic                        ref_on;
  logic [5:0]                  setting;
  logic                        at_t;
  logic                        ov;
  logic                        pwm_dis;
  logic                        ss_rst;
  int                          miscompares;
  int                          checks;

  vdsc_cpu_model u_vdsc_cpu_model (.req(req), .code_bit_400mv(b5), .code_bit_200mv(b4),
    .code_bit_100mv(b3), .code_bit_50mv(b2), .code_bit_25mv(b1), .code_bit_12p5mv(b0));

  vdsc_top u_vdsc_top (.mclk(mclk), .nrst(nrst), .ce(ce), .code_bit_400mv(b5), .code_bit_200mv(b4),
    .code_bit_100mv(b3), .code_bit_50mv(b2), .code_bit_25mv(b1), .code_bit_12p5mv(b0),
    .reference_setting_voltage(ref_v), .reference_on(ref_on), .setting_code(setting), .at_target(at_t),
    .ov_trip_shutdown_level(ov), .pwm_disable(pwm_dis), .softstart_restart(ss_rst));

  // 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // 0.1 mV units: 525 mV plus 12.5 mV per code step
  function automatic logic [15:0] ref_of(input logic [5:0] c);
    return 16'd5250 + 16'd125 * {10'h000, c};
  endfunction : ref_of

  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic t_reset();
    chk(ref_v, ref_of(6'h00));
    chk(setting, 16'h0000);
    chk(at_t, 16'h0001);
    chk({pwm_dis, ov}, 16'h0000);
    chk(ref_on, 16'h0000);
    chk(ss_rst, 16'h0000);
    nrst <= 1'b1;
    cyc(3);
    chk(ref_on, 16'h0001);
  endtask : t_reset

  // two samples at most: too short to qualify, so the match flag never drops
  task automatic t_glitch();
    int drops;
    drops = 0;
    req <= 6'h01;
    cyc(3);
    req <= 6'h00;
    repeat (200) begin
      cyc(1);
      if (at_t !== 1'b1) drops++;
    end
    chk(16'(drops), 16'h0000);
    chk(setting, 16'h0000);
  endtask : t_glitch

  task automatic t_first_step();
    int n;
    n = 0;
    req <= 6'h01;
    while (setting !== 6'h01 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(16'(n >= 80 && n <= 95), 16'h0001);
    cyc(2);
    chk(ref_v, ref_of(6'h01));
  endtask : t_first_step

  // walks of several codes: one lsb per 160 cycles
  task automatic t_walk(input logic [5:0] tgt);
    int         n;
    int         since;
    int         steps;
    logic [5:0] prev;
    req <= tgt;
    prev = setting;
    since = 0;
    steps = 0;
    n = 0;
    while (setting !== tgt && n < 12000) begin
      cyc(1);
      n++;
      since++;
      if (setting !== prev) begin
        if (steps > 0) chk(16'(since), 16'd160);
        chk(16'(setting > prev ? setting - prev : prev - setting), 16'h0001);
        prev = setting;
        since = 0;
        steps++;
      end
    end
    cyc(2);
    chk(setting, tgt);
    chk(ref_v, ref_of(tgt));
    chk(at_t, 16'h0001);
  endtask : t_walk

  // up request reversed to down before the half wait ends: the wait restarts
  task automatic t_reverse();
    logic seen_up;
    int   n;
    seen_up = 1'b0;
    n = 0;
    req <= 6'h06;
    cyc(30);
    req <= 6'h04;
    while (setting !== 6'h04 && n < 400) begin
      cyc(1);
      n++;
      if (setting === 6'h06) seen_up = 1'b1;
    end
    chk(seen_up, 16'h0000);
    chk(16'(n >= 80 && n <= 95), 16'h0001);
  endtask : t_reverse

  // clock enable low freezes sampling, waits and the setting
  task automatic t_freeze();
    int n;
    n = 0;
    ce <= 1'b0;
    req <= 6'h05;
    cyc(300);
    chk({at_t, setting}, 16'h0044);
    ce <= 1'b1;
    while (setting !== 6'h05 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(16'(n >= 80 && n <= 95), 16'h0001);
  endtask : t_freeze

  // reset in mid-run: everything returns to the reset values
  task automatic t_mid_reset();
    nrst <= 1'b0;
    req <= 6'h00;
    cyc(2);
    t_reset();
  endtask : t_mid_reset

  task automatic t_off();
    int n;
    n = 0;
    req <= vdsc_pkg::CODE_OFF;
    while (ov !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
      if (n == 12) chk(ref_on, 16'h0000);
    end
    chk(16'(n >= 320 && n <= 345), 16'h0001);
    chk(pwm_dis, 16'h0001);
    chk(setting, 16'h003e);
    n = 0;
    req <= 6'h3e;
    while (ss_rst !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(ss_rst, 16'h0001);
    cyc(2);
    chk({ss_rst, ref_on, pwm_dis, ov}, 16'h0004);
  endtask : t_off

  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    req = 6'h00;
    miscompares = 0;
    checks = 0;
    repeat (16) @(negedge mclk);
    t_reset();
    t_glitch();
    t_first_step();
    t_walk(6'h05);
    t_reverse();
    t_walk(6'h04);
    t_freeze();
    t_walk(6'h3e);
    t_off();
    t_mid_reset();
    tally_and_finish();
  end

  // hang guard, nearly four times the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench

// File: vdsc_code_qual.sv
/*
  code qualifier: samples the 6-bit request on a tick every second mclk cycle (20 MHz)
  and accepts a new code once three samples in a row agree.
  assumes the request pins are already synchronous to mclk.
*/
`timescale 1ns/1ps
module vdsc_code_qual (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  input  wire logic [vdsc_pkg::CODE_W-1:0]  code_raw,
  output logic      [vdsc_pkg::CODE_W-1:0]  code_q,
  output logic                              changed_q
);

  logic [vdsc_pkg::SMP_CNT_W-1:0] smp_cnt_q;
  logic [vdsc_pkg::CODE_W-1:0]    smp_q [vdsc_pkg::QUAL_SAMPLES];
  wire                            tick;
  wire                            all_eq;
  wire                            take;

  // sample tick and agreement of the three held samples
  assign tick   = (smp_cnt_q == vdsc_pkg::SAMPLE_LAST);
  assign all_eq = (smp_q[0] == smp_q[1]) && (smp_q[1] == smp_q[2]);
  assign take   = all_eq && (smp_q[0] != code_q);

  // tick divider
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      smp_cnt_q <= '0;
    end else if (ce) begin
      smp_cnt_q <= tick ? '0 : smp_cnt_q + 2'h1;
    end
  end

  // sample shift register, one stage per sampling edge
  genvar gi;
  generate
    for (gi = 0; gi < vdsc_pkg::QUAL_SAMPLES; gi++) begin : g_smp
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          smp_q[gi] <= vdsc_pkg::CODE_RST;
        end else if (ce && tick) begin
          smp_q[gi] <= (gi == 0) ? code_raw : smp_q[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // accepted code; a glitch shorter than three samples never gets here
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      code_q    <= vdsc_pkg::CODE_RST;
      changed_q <= 1'b0;
    end else if (ce) begin
      changed_q <= take;
      if (take) begin
        code_q <= smp_q[0];
      end
    end
  end

  property p_three_equal;
    @(posedge mclk) disable iff (!nrst)
      (code_q != $past(code_q)) |-> $past(all_eq) && (code_q == $past(smp_q[0]));
  endproperty
  a_three_equal: assert property (p_three_equal) else $error("code accepted without three equal samples");

endmodule : vdsc_code_qual

// File: vdsc_cpu_model.sv
/*
  processor side of the request pins: presents the six code bits.
  assumes the bench updates req at the falling edge of mclk.
*/
`timescale 1ns/1ps
module vdsc_cpu_model (
  input  wire logic [5:0] req,
  output logic            code_bit_400mv,
  output logic            code_bit_200mv,
  output logic            code_bit_100mv,
  output logic            code_bit_50mv,
  output logic            code_bit_25mv,
  output logic            code_bit_12p5mv
);
  // pins always driven: each bit follows req directly, no pull-ups involved
  assign {code_bit_400mv, code_bit_200mv, code_bit_100mv,
          code_bit_50mv, code_bit_25mv, code_bit_12p5mv} = req;
endmodule : vdsc_cpu_model

// File: vdsc_pkg.sv
/*
  constants shared by the voltage-code step controller: code widths,
  reference scaling, reset values, timing counts and the step state type.
  assumes a 40 MHz mclk; all counts are derived from it below.
*/
package vdsc_pkg;

  // code and reference formats
  localparam int          CODE_W        = 6;
  localparam int          REF_W         = 14;     // reference in units of 0.1 mV
  localparam logic [5:0]  CODE_OFF      = 6'h3f;  // all-ones: off, no reference
  localparam logic [5:0]  CODE_RST      = 6'h00;  // setting and request after reset
  localparam logic [13:0] REF_BASE      = 14'h1482; // 525.0 mV
  localparam logic [13:0] REF_LSB       = 14'h007d; // 12.5 mV per code step

  // clock and timing figures, periods in picoseconds
  localparam int          CLK_PERIOD_PS    = 25000;    // 40 MHz mclk
  localparam int          SAMPLE_PERIOD_PS = 62500;    // 16 MHz sampling clock
  localparam int          STEP_PERIOD_PS   = 4000000;  // 4 us per 12.5 mV step
  localparam int          QUAL_SAMPLES     = 3;        // equal samples to accept a code
  localparam int          OFF_DELAY_STEPS  = 2;        // step cycles before shutdown

  // derived cycle counts (periods round down, the sample count never below one)
  localparam int SAMPLE_CYC    = (SAMPLE_PERIOD_PS / CLK_PERIOD_PS) < 1 ? 1 : SAMPLE_PERIOD_PS / CLK_PERIOD_PS;
  localparam int STEP_CYC      = STEP_PERIOD_PS / CLK_PERIOD_PS;
  localparam int HALF_STEP_CYC = STEP_CYC / 2;
  localparam int OFF_DELAY_CYC = OFF_DELAY_STEPS * STEP_CYC;

  // counter widths and terminal values
  localparam int          SMP_CNT_W     = 2;
  localparam logic [1:0]  SAMPLE_LAST   = 2'(SAMPLE_CYC - 1);
  localparam int          CNT_W         = 9;
  localparam logic [8:0]  HALF_LAST     = 9'(HALF_STEP_CYC - 1);
  localparam logic [8:0]  STEP_LAST     = 9'(STEP_CYC - 1);
  localparam logic [8:0]  OFF_LAST      = 9'(OFF_DELAY_CYC - 1);

  // step sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_STEP,
    ST_OFF_DLY,
    ST_SHUT
  } vdsc_state_e;

endpackage : vdsc_pkg

// File: vdsc_top.sv
/*
  voltage-code step controller: turns the processor's 6-bit request into
  a reference setting that walks one 12.5 mV step at a time, and handles
  the all-ones off code with a delayed shutdown.
  assumes code pins synchronous to mclk (40 MHz); analog dac outside.
*/
`timescale 1ns/1ps
module vdsc_top (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  input  wire logic                         code_bit_400mv,
  input  wire logic                         code_bit_200mv,
  input  wire logic                         code_bit_100mv,
  input  wire logic                         code_bit_50mv,
  input  wire logic                         code_bit_25mv,
  input  wire logic                         code_bit_12p5mv,
  output logic      [vdsc_pkg::REF_W-1:0]   reference_setting_voltage,
  output logic                              reference_on,
  output logic      [vdsc_pkg::CODE_W-1:0]  setting_code,
  output logic                              at_target,
  output logic                              ov_trip_shutdown_level,
  output logic                              pwm_disable,
  output logic                              softstart_restart
);

  logic [vdsc_pkg::CODE_W-1:0] req_code;
  logic                        req_changed;
  logic [vdsc_pkg::CODE_W-1:0] dac_q;
  logic [vdsc_pkg::CODE_W-1:0] dac_d;
  logic [vdsc_pkg::CNT_W-1:0]  cnt_q;
  logic [vdsc_pkg::CNT_W-1:0]  cnt_d;
  logic                        up_q;
  logic                        up_d;
  logic                        shut_q;
  logic                        restart_q;
  logic [vdsc_pkg::REF_W-1:0]  ref_q;
  logic                        ref_on_q;
  logic                        match_q;
  vdsc_pkg::vdsc_state_e       state_q;
  vdsc_pkg::vdsc_state_e       state_d;

  wire [vdsc_pkg::CODE_W-1:0]  code_raw;
  wire                         req_up;
  wire                         req_dn;
  wire                         req_eq;
  wire                         req_off;
  wire                         reversed;
  wire [vdsc_pkg::CODE_W-1:0]  dac_toward;
  wire [vdsc_pkg::REF_W-1:0]   ref_decoded;

  // pins gathered into one code word, 400 mV bit on top
  assign code_raw = {code_bit_400mv, code_bit_200mv, code_bit_100mv,
                     code_bit_50mv, code_bit_25mv, code_bit_12p5mv};

  vdsc_code_qual u_qual (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .code_raw  (code_raw),
    .code_q    (req_code),
    .changed_q (req_changed)
  );

  // comparison of request against the held setting
  assign req_off    = (req_code == vdsc_pkg::CODE_OFF);
  assign req_up     = (req_code > dac_q);
  assign req_dn     = (req_code < dac_q);
  assign req_eq     = (req_code == dac_q);
  assign reversed   = up_q ? req_dn : req_up;
  assign dac_toward = req_up ? dac_q + 6'h01 : dac_q - 6'h01;

  // binary weighted decode: 12.5 mV per count above 525 mV
  assign ref_decoded = vdsc_pkg::REF_BASE + 14'(dac_q) * vdsc_pkg::REF_LSB;

  // step sequencer; the off code wins over any pending step
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 9'h001;
    up_d    = up_q;
    dac_d   = dac_q;
    case (state_q)
      vdsc_pkg::ST_IDLE: begin
        cnt_d = '0;
        if (req_off) begin
          state_d = vdsc_pkg::ST_OFF_DLY;
        end else if (!req_eq) begin
          state_d = vdsc_pkg::ST_WAIT;
          up_d    = req_up;
        end
      end
      vdsc_pkg::ST_WAIT: begin
        if (req_off) begin
          state_d = vdsc_pkg::ST_OFF_DLY;
          cnt_d   = '0;
        end else if (reversed || req_eq) begin
          state_d = vdsc_pkg::ST_IDLE;
        end else if (cnt_q == vdsc_pkg::HALF_LAST) begin
          dac_d   = dac_toward;
          state_d = vdsc_pkg::ST_STEP;
          cnt_d   = '0;
        end
      end
      vdsc_pkg::ST_STEP: begin
        if (req_off) begin
          state_d = vdsc_pkg::ST_OFF_DLY;
          cnt_d   = '0;
        end else if (req_eq) begin
          state_d = vdsc_pkg::ST_IDLE;
        end else if (cnt_q == vdsc_pkg::STEP_LAST) begin
          dac_d   = dac_toward;
          cnt_d   = '0;
        end
      end
      vdsc_pkg::ST_OFF_DLY: begin
        if (!req_off) begin
          state_d = vdsc_pkg::ST_IDLE;    // code withdrawn before shutdown
        end else if (cnt_q == vdsc_pkg::OFF_LAST) begin
          state_d = vdsc_pkg::ST_SHUT;
        end
      end
      vdsc_pkg::ST_SHUT: begin
        cnt_d = '0;
        if (!req_off) begin
          state_d = vdsc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = vdsc_pkg::ST_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= vdsc_pkg::ST_IDLE;
      cnt_q   <= '0;
      up_q    <= 1'b0;
      dac_q   <= vdsc_pkg::CODE_RST;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      up_q    <= up_d;
      dac_q   <= dac_d;
    end
  end

  // registered outputs; restart is a one-cycle pulse on leaving shutdown
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shut_q    <= 1'b0;
      restart_q <= 1'b0;
      ref_q     <= vdsc_pkg::REF_BASE;
      ref_on_q  <= 1'b0;
      match_q   <= 1'b1;
    end else if (ce) begin
      shut_q    <= (state_d == vdsc_pkg::ST_SHUT);
      restart_q <= (state_q == vdsc_pkg::ST_SHUT) && !req_off;
      ref_q     <= ref_decoded;
      ref_on_q  <= !req_off;
      match_q   <= req_eq;
    end
  end

  assign reference_setting_voltage = ref_q;
  assign reference_on              = ref_on_q;
  assign setting_code              = dac_q;
  assign at_target                 = match_q;
  assign ov_trip_shutdown_level    = shut_q;
  assign pwm_disable               = shut_q;
  assign softstart_restart         = restart_q;

  // checks
  sequence s_off_held;
    ce && req_off;
  endsequence

  sequence s_wait_active;
    ce && (state_q == vdsc_pkg::ST_WAIT) && !req_off;
  endsequence

  property p_decode;
    @(posedge mclk) disable iff (!nrst)
      ce |=> ref_q == vdsc_pkg::REF_BASE + 14'($past(dac_q)) * vdsc_pkg::REF_LSB;
  endproperty
  a_decode: assert property (p_decode) else $error("reference does not match setting");

  property p_off_no_ref;
    @(posedge mclk) disable iff (!nrst)
      s_off_held |=> !ref_on_q;
  endproperty
  a_off_no_ref: assert property (p_off_no_ref) else $error("reference on for off code");

  property p_half_wait;
    @(posedge mclk) disable iff (!nrst)
      (dac_q != $past(dac_q)) && ($past(state_q) == vdsc_pkg::ST_WAIT) |->
        $past(cnt_q) == vdsc_pkg::HALF_LAST;
  endproperty
  a_half_wait: assert property (p_half_wait) else $error("first step before half cycle");

  property p_cancel;
    @(posedge mclk) disable iff (!nrst)
      s_wait_active ##0 reversed |=> (state_q == vdsc_pkg::ST_IDLE) && $stable(dac_q);
  endproperty
  a_cancel: assert property (p_cancel) else $error("step not cancelled on sign reversal");

  property p_step_period;
    @(posedge mclk) disable iff (!nrst)
      (dac_q != $past(dac_q)) && ($past(state_q) == vdsc_pkg::ST_STEP) |->
        $past(cnt_q) == vdsc_pkg::STEP_LAST;
  endproperty
  a_step_period: assert property (p_step_period) else $error("step outside the 4 us period");

  property p_one_lsb;
    @(posedge mclk) disable iff (!nrst)
      (dac_q != $past(dac_q)) |->
        (dac_q == $past(dac_q) + 6'h01) || (dac_q == $past(dac_q) - 6'h01);
  endproperty
  a_one_lsb: assert property (p_one_lsb) else $error("setting moved by more than one step");

  property p_shut_delay;
    @(posedge mclk) disable iff (!nrst)
      $rose(shut_q) |-> ($past(state_q) == vdsc_pkg::ST_OFF_DLY) &&
        ($past(cnt_q) == vdsc_pkg::OFF_LAST) && $past(req_off);
  endproperty
  a_shut_delay: assert property (p_shut_delay) else $error("shutdown without two-cycle delay");

  property p_restart;
    @(posedge mclk) disable iff (!nrst)
      ce && shut_q && !req_off && (state_q == vdsc_pkg::ST_SHUT) |=> softstart_restart ##1 !softstart_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart pulse on leaving off code");

  property p_match;
    @(posedge mclk) disable iff (!nrst)
      ce |=> at_target == ($past(req_code) == $past(dac_q));
  endproperty
  a_match: assert property (p_match) else $error("match flag wrong");

  // the qualifier's change flag must mark exactly the cycles where the request moved
  property p_changed_flag;
    @(posedge mclk) disable iff (!nrst)
      ce |=> req_changed == (req_code != $past(req_code));
  endproperty
  a_changed_flag: assert property (p_changed_flag) else $error("change flag does not follow accepted code");

endmodule : vdsc_top
